//--- vmon_pkg.sv
package vmon_pkg;
    // ****************************************************
    // register offsets (byte addresses)
    // ****************************************************
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] status_off = 8'h04;
    localparam logic [7:0] mask_off = 8'h08;
    localparam logic [7:0] vout_off = 8'h0c;
    localparam logic [7:0] ov_warn_off = 8'h10;
    localparam logic [7:0] uv_fault_off = 8'h14;
    localparam logic [7:0] uv_warn_off = 8'h18;
    localparam logic [7:0] pg_on_off = 8'h1c;
    localparam logic [7:0] pg_off_off = 8'h20;
    localparam logic [7:0] ov_fault_off = 8'h24;
    localparam logic [7:0] vin_on_off = 8'h28;
    localparam logic [7:0] vin_off_off = 8'h2c;
    localparam logic [7:0] freq_off = 8'h30;
    localparam logic [7:0] pg_dly_off = 8'h34;
    localparam logic [7:0] cmd_off = 8'h38;
    localparam logic [7:0] vout_cmd_off = 8'h3c;
    // ****************************************************
    // control fields
    // ****************************************************
    localparam int ctrl_digital_bit = 0;
    localparam int ctrl_tracking_bit = 1;
    localparam int ctrl_ov_ignore_bit = 2;
    localparam int ctrl_no_divider_bit = 3;
    localparam int cmd_clear_bit = 0;
    // status bits
    localparam int st_ov_fault = 0;
    localparam int st_ov_warn = 1;
    localparam int st_uv_fault = 2;
    localparam int st_uv_warn = 3;
    localparam int st_vin_low = 4;
    localparam int st_width = 5;
    // ****************************************************
    // voltages in 1/256 V codes (16 bit); freq in kHz, pg delay in ms (4 bit)
    // ****************************************************
    localparam logic [15:0] pg_on_rst = 16'h0073;
    localparam logic [15:0] pg_off_rst = 16'h006b;
    localparam logic [15:0] ov_fault_rst = 16'h009b;
    localparam logic [15:0] pg_track_ofs = 16'h00a1;
    localparam logic [15:0] ov_track_ofs = 16'h00a8;
    localparam logic [15:0] ov_warn_rst = 16'h0090;
    localparam logic [15:0] uv_fault_rst = 16'h0066;
    localparam logic [15:0] uv_warn_rst = 16'h006c;
    localparam logic [15:0] vin_on_rst = 16'h0900;
    localparam logic [15:0] vin_off_rst = 16'h0800;
    localparam logic [15:0] vout_cmd_rst = 16'h0080;
    localparam logic [15:0] freq_rst = 16'h025f;
    localparam logic [3:0] pg_dly_rst = 4'h0;
    localparam logic [3:0] pg_dly_max = 4'ha;
    // ****************************************************
    // timing
    // ****************************************************
    localparam int clk_mhz = 250;
    localparam int ov_delay_ns = 200;
    localparam int ov_delay_cyc = (ov_delay_ns * clk_mhz) / 1000;
    localparam int ms_us = 1000;
    localparam int ms_cyc = ms_us * clk_mhz;
    localparam int sample_cyc = 64;
endpackage : vmon_pkg

//--- sample_if.sv
`timescale 1ns/1ps
interface sample_if;
    logic tick;
    logic [15:0] code;
    modport src (output tick, output code);
    modport dst (input tick, input code);
endinterface : sample_if

//--- vsense_sampler.sv
`timescale 1ns/1ps
module vsense_sampler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] vsense_code,
    sample_if.src smp
);
    typedef struct packed {
        logic [15:0] div;
        logic tick;
        logic [15:0] code;
    } smp_s;
    smp_s st_ff;
    smp_s nxt_st;
    assign smp.tick = st_ff.tick;
    assign smp.code = st_ff.code;
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.div == 16'(vmon_pkg::sample_cyc - 1)) begin
            nxt_st.div = 16'h0000;
            nxt_st.tick = 1'b1;
            nxt_st.code = vsense_code;
        end else begin
            nxt_st.div = st_ff.div + 16'h0001;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : vsense_sampler

//--- vout_sense_power_good_output_ovp_monitor.sv
// Functional notes
// - report sense voltage in 1/256 V steps
// - digitized warn and undervoltage comparisons
// - power good only inside window
// - digital mode programmable power good thresholds
// - no divider: clamp power good thresholds 630mV
// - digital mode power good delay 0..10 ms steps
// - default ov 0.605 V, tracking 1.2x
// - digital ov limit, clamp 655 mV above
// - ov trip after about 200 ns
// - trip latches high side off, power_good_output low
// - low side on until below threshold
// - latch cleared by enable rising edge or, in digital mode only, by command
// - ignore response keeps converting, still flags
// - switching frequency default 607 kHz readable
// - input uvlo thresholds programmable
`timescale 1ns/1ps
module vout_sense_power_good_output_ovp_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] vsense_code,
    input wire logic [15:0] tracking_reference_input,
    input wire logic [15:0] vin_code,
    input wire logic enable_in,
    input wire logic pwm_high_req,
    input wire logic pwm_low_req,
    output logic high_side_drive,
    output logic low_side_drive,
    output logic power_good_output,
    output logic power_good_oe,
    output logic vin_ok,
    output logic fault_alert_line,
    output logic fault_alert_oe,
    output logic irq
);
    localparam int st_w = vmon_pkg::st_width;

    // ****************************************************
    // state record
    // ****************************************************
    typedef struct packed {
        logic [3:0] ctrl;
        logic [st_w-1:0] status;
        logic [st_w-1:0] mask;
        logic [15:0] ov_warn;
        logic [15:0] uv_fault;
        logic [15:0] uv_warn;
        logic [15:0] pg_on;
        logic [15:0] pg_off;
        logic [15:0] ov_fault;
        logic [15:0] vin_on;
        logic [15:0] vin_off;
        logic [15:0] freq;
        logic [15:0] vout_cmd;
        logic [3:0] pg_dly;
        logic [15:0] vout;
        logic [1:0] en_sync;
        logic en_prev;
        logic [15:0] vs0;
        logic [15:0] vs1;
        logic [15:0] vp0;
        logic [15:0] vp1;
        logic [15:0] vi0;
        logic [15:0] vi1;
        logic [7:0] ov_cnt;
        logic ov_trip;
        logic hs_latch;
        logic ls_force;
        logic pg_in;
        logic [3:0] pg_ms;
        logic [17:0] ms_div;
        logic pg;
        logic vin_good;
        logic [31:0] rdata;
    } mon_s;

    mon_s st_ff;
    mon_s nxt_st;
    logic [15:0] pg_hi;
    logic [15:0] pg_lo;
    logic [15:0] ov_th;
    logic [16:0] vp_x12;
    logic [16:0] lim_sum;
    logic [st_w-1:0] ev;
    logic wr_acc;
    logic rd_acc;
    logic dig;
    logic no_div;

    // ****************************************************
    // voltage sampler
    // ****************************************************
    sample_if smp ();
    // fed from the synchronised code, never straight from the pin
    vsense_sampler u_sampler (
        .pclk(pclk),
        .presetn(presetn),
        .vsense_code(st_ff.vs1),
        .smp(smp)
    );

    // ****************************************************
    // pins and bus answer
    // ****************************************************
    // zero wait states: setup then one access cycle
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = st_ff.rdata;
    assign high_side_drive = pwm_high_req && !st_ff.hs_latch;
    assign low_side_drive = st_ff.ls_force || (pwm_low_req && !st_ff.hs_latch);
    // open drain: drive low only
    assign power_good_output = 1'b0;
    assign power_good_oe = !st_ff.pg;
    assign fault_alert_line = 1'b0;
    assign fault_alert_oe = irq;
    assign vin_ok = st_ff.vin_good;
    assign irq = |(st_ff.status & st_ff.mask);
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign dig = st_ff.ctrl[vmon_pkg::ctrl_digital_bit];
    assign no_div = st_ff.ctrl[vmon_pkg::ctrl_no_divider_bit];

    // ****************************************************
    // active thresholds
    // ****************************************************
    always_comb begin
        pg_hi = vmon_pkg::pg_on_rst;
        pg_lo = vmon_pkg::pg_off_rst;
        if (dig) begin
            pg_hi = st_ff.pg_on;
            pg_lo = st_ff.pg_off;
            if (no_div) begin
                lim_sum = {1'b0, st_ff.vout_cmd} + {1'b0, vmon_pkg::pg_track_ofs};
                if ({1'b0, pg_hi} > lim_sum) begin
                    pg_hi = lim_sum[15:0];
                end
                if ({1'b0, pg_lo} > lim_sum) begin
                    pg_lo = lim_sum[15:0];
                end
                if ({1'b0, pg_lo} + {1'b0, vmon_pkg::pg_track_ofs} < {1'b0, st_ff.vout_cmd}) begin
                    pg_lo = st_ff.vout_cmd - vmon_pkg::pg_track_ofs;
                end
                if ({1'b0, pg_hi} + {1'b0, vmon_pkg::pg_track_ofs} < {1'b0, st_ff.vout_cmd}) begin
                    pg_hi = st_ff.vout_cmd - vmon_pkg::pg_track_ofs;
                end
            end
        end
        // spare top bit so a high limit cannot wrap
        lim_sum = {1'b0, st_ff.vout_cmd} + {1'b0, vmon_pkg::ov_track_ofs};
        vp_x12 = {1'b0, st_ff.vp1} + 17'({1'b0, st_ff.vp1} / 17'd5);
        if (st_ff.ctrl[vmon_pkg::ctrl_tracking_bit]) begin
            ov_th = vp_x12[16] ? 16'hffff : vp_x12[15:0];
        end else if (dig) begin
            ov_th = st_ff.ov_fault;
            if (no_div && ({1'b0, ov_th} > lim_sum)) begin
                ov_th = lim_sum[15:0];
            end
        end else begin
            ov_th = vmon_pkg::ov_fault_rst;
        end
    end

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        nxt_st = st_ff;
        ev = '0;
        // pins cross in through two flops each
        nxt_st.en_sync = {st_ff.en_sync[0], enable_in};
        nxt_st.en_prev = st_ff.en_sync[1];
        nxt_st.vs0 = vsense_code;
        nxt_st.vs1 = st_ff.vs0;
        nxt_st.vp0 = tracking_reference_input;
        nxt_st.vp1 = st_ff.vp0;
        nxt_st.vi0 = vin_code;
        nxt_st.vi1 = st_ff.vi0;

        if (st_ff.vs1 > ov_th) begin
            if (st_ff.ov_cnt < 8'(vmon_pkg::ov_delay_cyc - 2)) begin
                nxt_st.ov_cnt = st_ff.ov_cnt + 8'h01;
            end else begin
                nxt_st.ov_trip = 1'b1;
            end
        end else begin
            nxt_st.ov_cnt = 8'h00;
            nxt_st.ov_trip = 1'b0;
        end
        if (nxt_st.ov_trip && !st_ff.ov_trip) begin
            ev[vmon_pkg::st_ov_fault] = 1'b1;
        end
        if (st_ff.ov_trip && !st_ff.ctrl[vmon_pkg::ctrl_ov_ignore_bit]) begin
            nxt_st.hs_latch = 1'b1;
            nxt_st.ls_force = 1'b1;
        end
        if (!st_ff.ov_trip) begin
            nxt_st.ls_force = 1'b0;
        end
        if (st_ff.en_sync[1] && !st_ff.en_prev) begin
            nxt_st.hs_latch = 1'b0;
        end

        if (st_ff.vs1 >= pg_hi && st_ff.vs1 <= ov_th) begin
            nxt_st.pg_in = 1'b1;
        end else if (st_ff.vs1 < pg_lo || st_ff.vs1 > ov_th) begin
            nxt_st.pg_in = 1'b0;
        end
        nxt_st.ms_div = (st_ff.ms_div == 18'(vmon_pkg::ms_cyc - 1)) ? 18'h00000 : st_ff.ms_div + 18'h00001;
        if (!st_ff.pg_in || st_ff.hs_latch) begin
            nxt_st.pg = 1'b0;
            nxt_st.pg_ms = 4'h0;
            nxt_st.ms_div = 18'h00000;
        end else if (!dig || st_ff.pg_ms >= st_ff.pg_dly) begin
            nxt_st.pg = 1'b1;
        end else if (st_ff.ms_div == 18'(vmon_pkg::ms_cyc - 1)) begin
            nxt_st.pg_ms = st_ff.pg_ms + 4'h1;
        end
        if (st_ff.ov_trip && !st_ff.ctrl[vmon_pkg::ctrl_ov_ignore_bit]) begin
            nxt_st.pg = 1'b0;
        end

        if (smp.tick) begin
            nxt_st.vout = smp.code;
            ev[vmon_pkg::st_ov_warn] = smp.code > st_ff.ov_warn;
            ev[vmon_pkg::st_uv_fault] = smp.code < st_ff.uv_fault;
            ev[vmon_pkg::st_uv_warn] = smp.code < st_ff.uv_warn;
        end
        if (st_ff.vi1 >= st_ff.vin_on) begin
            nxt_st.vin_good = 1'b1;
        end else if (st_ff.vi1 < st_ff.vin_off) begin
            nxt_st.vin_good = 1'b0;
        end
        ev[vmon_pkg::st_vin_low] = st_ff.vin_good && !nxt_st.vin_good;

        // ****************************************************
        // register writes
        // ****************************************************
        if (wr_acc) begin
            unique case (paddr)
                vmon_pkg::ctrl_off: nxt_st.ctrl = pwdata[3:0];
                vmon_pkg::status_off: nxt_st.status = st_ff.status & ~pwdata[st_w-1:0];
                vmon_pkg::mask_off: nxt_st.mask = pwdata[st_w-1:0];
                vmon_pkg::ov_warn_off: nxt_st.ov_warn = pwdata[15:0];
                vmon_pkg::uv_fault_off: nxt_st.uv_fault = pwdata[15:0];
                vmon_pkg::uv_warn_off: nxt_st.uv_warn = pwdata[15:0];
                vmon_pkg::pg_on_off: nxt_st.pg_on = pwdata[15:0];
                vmon_pkg::pg_off_off: nxt_st.pg_off = pwdata[15:0];
                vmon_pkg::ov_fault_off: nxt_st.ov_fault = pwdata[15:0];
                vmon_pkg::vin_on_off: nxt_st.vin_on = pwdata[15:0];
                vmon_pkg::vin_off_off: nxt_st.vin_off = pwdata[15:0];
                vmon_pkg::freq_off: nxt_st.freq = pwdata[15:0];
                vmon_pkg::pg_dly_off: begin
                    nxt_st.pg_dly = (pwdata[3:0] > vmon_pkg::pg_dly_max) ? vmon_pkg::pg_dly_max : pwdata[3:0];
                end
                vmon_pkg::vout_cmd_off: nxt_st.vout_cmd = pwdata[15:0];
                vmon_pkg::cmd_off: begin
                    if (dig && pwdata[vmon_pkg::cmd_clear_bit]) begin
                        nxt_st.hs_latch = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // ****************************************************
        // status and alert
        // ****************************************************
        // set wins over clear
        nxt_st.status = nxt_st.status | ev;

        // ****************************************************
        // read data
        // ****************************************************
        // read data captured in setup, valid in access phase
        if (rd_acc) begin
            unique case (paddr)
                vmon_pkg::ctrl_off: nxt_st.rdata = {28'h0000000, st_ff.ctrl};
                vmon_pkg::status_off: nxt_st.rdata = {27'h0000000, st_ff.status};
                vmon_pkg::mask_off: nxt_st.rdata = {27'h0000000, st_ff.mask};
                vmon_pkg::vout_off: nxt_st.rdata = {16'h0000, st_ff.vout};
                vmon_pkg::ov_warn_off: nxt_st.rdata = {16'h0000, st_ff.ov_warn};
                vmon_pkg::uv_fault_off: nxt_st.rdata = {16'h0000, st_ff.uv_fault};
                vmon_pkg::uv_warn_off: nxt_st.rdata = {16'h0000, st_ff.uv_warn};
                vmon_pkg::pg_on_off: nxt_st.rdata = {16'h0000, st_ff.pg_on};
                vmon_pkg::pg_off_off: nxt_st.rdata = {16'h0000, st_ff.pg_off};
                vmon_pkg::ov_fault_off: nxt_st.rdata = {16'h0000, st_ff.ov_fault};
                vmon_pkg::vin_on_off: nxt_st.rdata = {16'h0000, st_ff.vin_on};
                vmon_pkg::vin_off_off: nxt_st.rdata = {16'h0000, st_ff.vin_off};
                vmon_pkg::freq_off: nxt_st.rdata = {16'h0000, st_ff.freq};
                vmon_pkg::pg_dly_off: nxt_st.rdata = {28'h0000000, st_ff.pg_dly};
                vmon_pkg::vout_cmd_off: nxt_st.rdata = {16'h0000, st_ff.vout_cmd};
                vmon_pkg::cmd_off: nxt_st.rdata = {30'h00000000, st_ff.ls_force, st_ff.hs_latch};
                default: nxt_st.rdata = 32'h00000000;
            endcase
        end
    end

    // ****************************************************
    // state registers
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.ov_warn <= vmon_pkg::ov_warn_rst;
            st_ff.uv_fault <= vmon_pkg::uv_fault_rst;
            st_ff.uv_warn <= vmon_pkg::uv_warn_rst;
            st_ff.pg_on <= vmon_pkg::pg_on_rst;
            st_ff.pg_off <= vmon_pkg::pg_off_rst;
            st_ff.ov_fault <= vmon_pkg::ov_fault_rst;
            st_ff.vin_on <= vmon_pkg::vin_on_rst;
            st_ff.vin_off <= vmon_pkg::vin_off_rst;
            st_ff.freq <= vmon_pkg::freq_rst;
            st_ff.vout_cmd <= vmon_pkg::vout_cmd_rst;
            st_ff.pg_dly <= vmon_pkg::pg_dly_rst;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : vout_sense_power_good_output_ovp_monitor

//--- vmon_props.sv
`timescale 1ns/1ps
module vmon_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [15:0] vsense_code,
    input wire logic enable_in,
    input wire logic pwm_high_req,
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    input wire logic power_good_oe,
    input wire logic fault_alert_oe,
    input wire logic irq
);
    logic [3:0] ctrl_ff;
    logic [7:0] hi_cnt_ff;
    logic [7:0] lo_cnt_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************************
    // shadow of the control word, dwell counters
    // ****************************************************
    // counters only run in plain analog mode, where thresholds are fixed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 4'h0;
            hi_cnt_ff <= 8'h00;
            lo_cnt_ff <= 8'h00;
        end else begin
            if (psel && penable && pwrite && paddr == 8'h00) begin
                ctrl_ff <= pwdata[3:0];
            end
            if (ctrl_ff == 4'h0 && enable_in && vsense_code > 16'h009b) begin
                hi_cnt_ff <= (hi_cnt_ff == 8'hff) ? hi_cnt_ff : hi_cnt_ff + 8'h01;
            end else begin
                hi_cnt_ff <= 8'h00;
            end
            if (ctrl_ff == 4'h0 && vsense_code < 16'h006b) begin
                lo_cnt_ff <= (lo_cnt_ff == 8'hff) ? lo_cnt_ff : lo_cnt_ff + 8'h01;
            end else begin
                lo_cnt_ff <= 8'h00;
            end
        end
    end
    ov_trip_hs_a: assert property (hi_cnt_ff >= 8'h46 |-> !high_side_drive)
        else $error("high side still on after overvoltage dwell");
    hs_needs_pwm_a: assert property (high_side_drive |-> pwm_high_req)
        else $error("high side on without pwm request");
    ls_forced_a: assert property (hi_cnt_ff >= 8'h46 |-> low_side_drive)
        else $error("low side not forced during overvoltage");
    pg_low_ov_a: assert property (hi_cnt_ff >= 8'h46 |-> power_good_oe)
        else $error("power good during overvoltage");
    pg_below_win_a: assert property (lo_cnt_ff >= 8'h08 |-> power_good_oe)
        else $error("power good below window");
    alert_irq_a: assert property (fault_alert_oe == irq)
        else $error("alert line differs from irq");
    rdata_hold_a: assert property (!(psel && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    freq_read_a: assert property (psel && penable && !pwrite && paddr == 8'h30 |-> prdata == 32'h0000025f)
        else $error("frequency readback wrong");
endmodule : vmon_props

bind vout_sense_power_good_output_ovp_monitor vmon_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .vsense_code(vsense_code), .enable_in(enable_in), .pwm_high_req(pwm_high_req),
    .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .power_good_oe(power_good_oe), .fault_alert_oe(fault_alert_oe), .irq(irq));

//--- stage_model.sv
`timescale 1ns/1ps
module stage_model #(
    parameter int slew = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] target,
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    output logic [15:0] vsense_code,
    output logic [15:0] shoot_cnt
);
    // ****************************************************
    // output node slews, a step larger than slew is never instant
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vsense_code <= 16'h0000;
            shoot_cnt <= 16'h0000;
        end else begin
            if (vsense_code + 16'(slew) < target) begin
                vsense_code <= vsense_code + 16'(slew);
            end else if (vsense_code > target + 16'(slew)) begin
                vsense_code <= vsense_code - 16'(slew);
            end else begin
                vsense_code <= target;
            end
            if (high_side_drive && low_side_drive) begin
                shoot_cnt <= shoot_cnt + 16'h0001;
            end
        end
    end
endmodule : stage_model

//--- test_vout_sense_power_good_output_ovp_monitor.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_vout_sense_power_good_output_ovp_monitor;
    logic pclk, presetn, psel, penable, pwrite, enable_in, pwm_high_req, pwm_low_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] vsense_code, tracking_reference_input, vin_code, tgt, shoot_cnt;
    logic pready, pslverr, high_side_drive, low_side_drive, power_good_output, power_good_oe;
    logic vin_ok, fault_alert_line, fault_alert_oe, irq;
    int error_cnt = 0;
    int tests_run = 0;
    vout_sense_power_good_output_ovp_monitor dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .vsense_code, .tracking_reference_input, .vin_code, .enable_in,
        .pwm_high_req, .pwm_low_req, .high_side_drive, .low_side_drive, .power_good_output,
        .power_good_oe, .vin_ok, .fault_alert_line, .fault_alert_oe, .irq);
    stage_model #(.slew(8)) stage_u (.pclk, .presetn, .target(tgt), .high_side_drive,
        .low_side_drive, .vsense_code, .shoot_cnt);
    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk_reg(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(n, e, rd)
    endtask : chk_reg
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : cyc
    task automatic set_vs(input logic [15:0] v, input int n);
        @(posedge pclk);
        tgt <= v;
        cyc(n);
    endtask : set_vs
    // expected flags: {vin_low, uv_warn, uv_fault, ov_warn, ov_fault}
    function automatic logic [4:0] exp_st(input logic [15:0] v, input logic [15:0] thr);
        return {1'b0, v < vmon_pkg::uv_warn_rst, v < vmon_pkg::uv_fault_rst, v > vmon_pkg::ov_warn_rst, v > thr};
    endfunction : exp_st
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // whole run is near 6k cycles, so 50k cycles means a hang
    initial begin
        #200000;
        error_cnt++;
        $display("[FAIL] watchdog exp done got hang");
        complete_run();
    end
    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        logic [15:0] v;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tgt, tracking_reference_input, vin_code} = {16'h006f, 16'h0080, 16'h0a00};
        {enable_in, pwm_high_req, pwm_low_req} = 3'b110;
        void'($urandom(32'h835c));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk_reg("freq", vmon_pkg::freq_off, 32'h0000025f);
        chk_reg("pg_on", vmon_pkg::pg_on_off, 32'h73);
        chk_reg("pg_off", vmon_pkg::pg_off_off, 32'h6b);
        chk_reg("ov_lim", vmon_pkg::ov_fault_off, 32'h9b);
        chk_reg("unmapped", 8'hfc, 32'h0);
        set_vs(16'h006f, 40);
        `CHK("pg_in", 1'b1, power_good_oe)
        `CHK("vin_ok", 1'b1, vin_ok)
        set_vs(16'h0078, 40);
        `CHK("pg_above", 1'b0, power_good_oe)
        apb(1'b1, vmon_pkg::mask_off, 32'h1f);
        for (int i = 0; i < 8; i++) begin
            v = 16'h0040 + 16'($urandom % 88);
            if (v == 16'h0066 || v == 16'h006c || v == 16'h0090) v++;
            @(posedge pclk) pwm_high_req <= i[0];
            pwm_low_req <= !i[0];
            set_vs(v, 200);
            `CHK("hs_pwm", i[0], high_side_drive)
            apb(1'b1, vmon_pkg::status_off, 32'h1f);
            cyc(200);
            chk_reg("vout", vmon_pkg::vout_off, {16'h0, v});
            chk_reg("status", vmon_pkg::status_off, {27'h0, exp_st(v, vmon_pkg::ov_fault_rst)});
            cyc(2);
            `CHK("irq", |exp_st(v, vmon_pkg::ov_fault_rst), irq)
        end
        @(posedge pclk) {pwm_high_req, pwm_low_req} <= 2'b10;
        set_vs(16'h0050, 200);
        apb(1'b1, vmon_pkg::mask_off, 32'h0);
        cyc(2);
        `CHK("irq_mask", 1'b0, irq)
        apb(1'b1, vmon_pkg::mask_off, 32'h1f);
        cyc(2);
        `CHK("alert", 1'b1, fault_alert_oe)
        set_vs(16'h006f, 200);
        apb(1'b1, vmon_pkg::status_off, 32'h1f);
        cyc(2);
        `CHK("irq_clr", 1'b0, irq)
        set_vs(16'h00a0, 20);
        `CHK("hs_early", 1'b1, high_side_drive)
        cyc(100);
        `CHK("hs_latch", 1'b0, high_side_drive)
        `CHK("pg_ov", 1'b1, power_good_oe)
        `CHK("ls_on", 1'b1, low_side_drive)
        chk_reg("ov_flag", vmon_pkg::status_off, {27'h0, exp_st(16'h00a0, vmon_pkg::ov_fault_rst)});
        set_vs(16'h006f, 100);
        `CHK("ls_off", 1'b0, low_side_drive)
        `CHK("hs_held", 1'b0, high_side_drive)
        @(posedge pclk) enable_in <= 1'b0;
        cyc(4);
        @(posedge pclk) enable_in <= 1'b1;
        cyc(4);
        `CHK("hs_en", 1'b1, high_side_drive)
        apb(1'b1, vmon_pkg::ctrl_off, 32'h1);
        apb(1'b1, vmon_pkg::ov_fault_off, 32'h90);
        set_vs(16'h0098, 100);
        `CHK("hs_lim", 1'b0, high_side_drive)
        set_vs(16'h006f, 100);
        apb(1'b1, vmon_pkg::cmd_off, 32'h1);
        cyc(2);
        `CHK("hs_cmd", 1'b1, high_side_drive)
        apb(1'b1, vmon_pkg::ctrl_off, 32'h5);
        apb(1'b1, vmon_pkg::status_off, 32'h1f);
        set_vs(16'h00a0, 100);
        `CHK("hs_ign", 1'b1, high_side_drive)
        chk_reg("ign_flag", vmon_pkg::status_off, {27'h0, exp_st(16'h00a0, 16'h0090)});
        `CHK("ign_irq", 1'b1, fault_alert_oe)
        set_vs(16'h006f, 100);
        apb(1'b1, vmon_pkg::ctrl_off, 32'h2);
        tracking_reference_input <= 16'h0060;
        set_vs(16'h0080, 100);
        `CHK("hs_trk", 1'b0, high_side_drive)
        apb(1'b1, vmon_pkg::pg_on_off, 32'h88);
        apb(1'b1, vmon_pkg::pg_off_off, 32'h78);
        apb(1'b1, vmon_pkg::ctrl_off, 32'h1);
        apb(1'b1, vmon_pkg::cmd_off, 32'h1);
        set_vs(16'h0080, 40);
        `CHK("pg_prog", 1'b1, power_good_oe)
        apb(1'b1, vmon_pkg::pg_dly_off, 32'hf);
        chk_reg("pg_dly", vmon_pkg::pg_dly_off, 32'ha);
        set_vs(16'h0060, 40);
        set_vs(16'h008c, 1000);
        `CHK("pg_dly_hold", 1'b1, power_good_oe)
        apb(1'b1, vmon_pkg::pg_dly_off, 32'h0);
        cyc(2);
        `CHK("pg_dly0", 1'b0, power_good_oe)
        apb(1'b1, vmon_pkg::vin_on_off, 32'h0b00);
        apb(1'b1, vmon_pkg::vin_off_off, 32'h0a80);
        cyc(200);
        `CHK("vin_low", 1'b0, vin_ok)
        `CHK("shoot", 16'h0, shoot_cnt)
        complete_run();
    end
endmodule : test_vout_sense_power_good_output_ovp_monitor
